// *** encoder_counter_defs.vh ***
// Purpose: constants for the dual absolute encoder counter
// Assumes: Avalon-MM word addressing, 32-bit data, 125 MHz clock
// Notes: register indices are word addresses
`ifndef ENCODER_COUNTER_DEFS_VH
`define ENCODER_COUNTER_DEFS_VH

// register word addresses
`define REG_P1_POS_LOW 6'h00
`define REG_P1_POS_HIGH 6'h01
`define REG_P2_POS_LOW 6'h02
`define REG_P2_POS_HIGH 6'h03
`define REG_P1_STATUS 6'h04
`define REG_P2_STATUS 6'h05
`define REG_ORIGIN_CTRL 6'h06
`define REG_FAULT_FLAG 6'h07
`define REG_ERROR_CODE 6'h08
`define REG_P1_OFFSET 6'h09
`define REG_P2_OFFSET 6'h0A
`define REG_P1_CONFIG 6'h0B
`define REG_P2_CONFIG 6'h0C
`define REG_RUN_CTRL 6'h0D
`define REG_COMMAND 6'h0E
`define REG_RESULT 6'h0F
`define REG_TABLE_BASE 6'h10
`define REG_TABLE_LAST 6'h1F

// field positions
`define RUN_BIT 0
`define MASK_BIT 1
`define P1_ORIGIN_BIT 1
`define P2_ORIGIN_BIT 2
`define FAULT_BIT 15
`define STATUS_RUN_BIT 8
`define CMD_PORT_BIT 4

// reset values
`define CONFIG_RESET 16'h0000
`define OFFSET_RESET 16'h0000

// codes
`define RES_8 8'h00
`define RES_10 8'h01
`define RES_12 8'h02
`define MODE_COUNTS 8'h00
`define MODE_ANGLE 8'h01
`define ERR_NONE 8'h00
`define ERR_SETUP 8'h03
`define OP_TABLE 2'h0
`define OP_CONTROL 2'h1
`define OP_READ 2'h2
`define CTRL_START 2'h0
`define CTRL_STOP 2'h1
`define CTRL_PRESET 2'h2

// counts for 0 to 45 degrees, one 12-bit entry per 5-degree step
`define ANGLE_STEPS_8 120'h020_01C_019_015_012_00E_00B_007_004_000
`define ANGLE_STEPS_10 120'h080_072_064_055_047_039_02B_01C_00E_000
`define ANGLE_STEPS_12 120'h200_1C7_18E_155_11C_0E4_0AB_072_039_000

// timing
`define CLK_FREQ_HZ 125000000
`define SAMPLE_RATE_HZ 4000
`define SAMPLE_CYCLES (`CLK_FREQ_HZ / `SAMPLE_RATE_HZ)

`endif

// *** dual_absolute_encoder_counter.v ***
// Purpose: two absolute gray-code encoder counters with compare tables
// Assumes: encoder words are asynchronous to clk; Avalon-MM slave access
// Notes: table words hold lower/target in [15:0], upper in [31:16]
//
// Overview of operation
// - two counters, one per port, each with its own setup and flags.
// - each port samples its gray-code input at 4 kHz.
// - counts mode converts gray to binary, then binary to BCD.
// - angle mode scales full span to 360 degrees, output 0 to 359.
// - resolution 8, 10 or 12 bits; counts mode spans 255, 1023, 4095.
// - angle table values converted to counts per resolution by fixed table.
// - above 45 degrees count is c45 times quotient plus remainder count.
// - position kept as 4-digit BCD in the low word each sample; high word reads zero.
// - status bit 8 high while comparison runs.
// - origin bit in program mode applies stored BCD offset 0000 to 4095.
// - fault flag at bit 15 and 8-bit error code, 3 for setup fault.
// - table command stores target or range table, optionally starting.
// - control command starts, stops comparison or overwrites position.
// - read command returns position or status of addressed port.
// - global mask suppresses comparison interrupts.
// - interrupt when position equals target or lies within a range.
// - configuration resets to zero, counts mode with 8-bit resolution.
`timescale 1ns/1ns
`include "encoder_counter_defs.vh"

module dual_absolute_encoder_counter #(
   parameter SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
   input wire clk, // 125 MHz clock
   input wire reset_n, // asynchronous reset
   input wire [5:0] avs_address, // word address
   input wire avs_read, // read request
   input wire avs_write, // write request
   input wire [31:0] avs_writedata, // write data
   output reg [31:0] avs_readdata, // read data
   output reg avs_waitrequest, // stall
   input wire [11:0] enc1_gray, // port 1 encoder word
   input wire [11:0] enc2_gray, // port 2 encoder word
   output reg compare_irq // one-cycle comparison interrupt
);

   function [11:0] gray_to_bin;
      input [11:0] g;
      integer i;
      begin
         gray_to_bin[11] = g[11];
         for (i = 10; i >= 0; i = i - 1) begin
            gray_to_bin[i] = gray_to_bin[i + 1] ^ g[i];
         end
      end
   endfunction

   function [15:0] bin_to_bcd;
      input [11:0] b;
      integer i;
      integer d;
      reg [27:0] s;
      begin
         s = {16'h0000, b};
         for (i = 0; i < 12; i = i + 1) begin
            for (d = 0; d < 4; d = d + 1) begin
               if (s[12 + d * 4 +: 4] >= 4'h5) begin
                  s[12 + d * 4 +: 4] = s[12 + d * 4 +: 4] + 4'h3;
               end
            end
            s = {s[26:0], 1'b0};
         end
         bin_to_bcd = s[27:12];
      end
   endfunction

   function [13:0] bcd_to_bin;
      input [15:0] d;
      begin
         bcd_to_bin = {10'h000, d[15:12]} * 14'h03E8 + {10'h000, d[11:8]} * 14'h0064
            + {10'h000, d[7:4]} * 14'h000A + {10'h000, d[3:0]};
      end
   endfunction

   function [11:0] res_mask;
      input [7:0] res;
      begin
         case (res)
            `RES_8: res_mask = 12'h0FF;
            `RES_10: res_mask = 12'h3FF;
            default: res_mask = 12'hFFF;
         endcase
      end
   endfunction

   // counts for 0..45 degrees in 5-degree steps
   function [11:0] angle_step;
      input [7:0] res;
      input [3:0] k;
      reg [119:0] t;
      begin
         case (res)
            `RES_8: t = `ANGLE_STEPS_8;
            `RES_10: t = `ANGLE_STEPS_10;
            default: t = `ANGLE_STEPS_12;
         endcase
         angle_step = (k > 4'h9) ? 12'h000 : t[k * 12 +: 12];
      end
   endfunction

   // table entry (BCD) to comparison counts
   function [11:0] table_to_count;
      input [7:0] mode;
      input [7:0] res;
      input [15:0] bcd;
      reg [13:0] v;
      reg [13:0] q;
      reg [13:0] r;
      reg [23:0] prod;
      reg [13:0] k;
      begin
         v = bcd_to_bin(bcd);
         q = v / 14'h002D;
         r = v - q * 14'h002D;
         k = r / 14'h0005;
         prod = {12'h000, angle_step(res, 4'h9)} * {10'h000, q}
            + {12'h000, angle_step(res, k[3:0])};
         if (mode == `MODE_ANGLE) begin
            table_to_count = prod[11:0];
         end else begin
            table_to_count = v[11:0];
         end
      end
   endfunction

   reg [23:0] sync1;
   reg [23:0] sync2;
   reg [23:0] sync3;
   reg [23:0] enc_stable;
   reg [23:0] enc_sample;
   reg [15:0] cfg_reg [0:1];
   reg [15:0] offset_reg [0:1];
   reg [7:0] res_run [0:1];
   reg [7:0] mode_run [0:1];
   reg [11:0] offset_active [0:1];
   reg [31:0] tbl [0:15];
   reg [1:0] table_range;
   reg [1:0] comparing;
   reg [15:0] range_flags;
   reg [1:0] match_prev;
   reg [31:0] pos_bcd;
   reg [2:1] origin_bits;
   reg run;
   reg irq_mask;
   reg fault;
   reg [7:0] err_code;
   reg [31:0] result;
   reg [16:0] tick_cnt;
   reg tick;
   reg run_prev;
   reg [31:0] rd_mux;

   wire [23:0] adj_all;
   wire [23:0] pv_all;
   wire [15:0] in_range;
   wire [15:0] on_target;
   wire [1:0] any_match;
   wire [23:0] enc_in;
   wire access;
   wire [5:0] tidx;
   wire [7:0] new_res0;
   wire [7:0] new_res1;
   wire [13:0] preset_off;
   wire [13:0] origin_bin0;
   wire [13:0] origin_bin1;

   assign enc_in = {enc2_gray, enc1_gray};
   assign access = (avs_read | avs_write) & ~avs_waitrequest;
   assign tidx = avs_address - `REG_TABLE_BASE;
   assign new_res0 = cfg_reg[0][7:0];
   assign new_res1 = cfg_reg[1][7:0];
   assign origin_bin0 = bcd_to_bin(offset_reg[0]);
   assign origin_bin1 = bcd_to_bin(offset_reg[1]);
   assign preset_off = {2'h0, (avs_writedata[`CMD_PORT_BIT] ? adj_all[23:12] :
      adj_all[11:0])} + {2'h0, offset_active[avs_writedata[`CMD_PORT_BIT]]}
      - bcd_to_bin(avs_writedata[31:16]);

   genvar p;
   genvar e;
   generate
      for (p = 0; p < 2; p = p + 1) begin : g_port
         wire [11:0] mask;
         wire [11:0] raw;
         wire [11:0] adj;
         wire [20:0] deg_prod;
         wire [20:0] deg_shift;
         assign mask = res_mask(res_run[p]);
         assign raw = gray_to_bin(enc_sample[p * 12 +: 12] & mask);
         assign adj = (raw - offset_active[p]) & mask;
         assign deg_prod = {9'h000, adj} * 21'h000168;
         assign deg_shift = (res_run[p] == `RES_8) ? (deg_prod >> 8) :
            (res_run[p] == `RES_10) ? (deg_prod >> 10) : (deg_prod >> 12);
         assign adj_all[p * 12 +: 12] = adj;
         assign pv_all[p * 12 +: 12] = (mode_run[p] == `MODE_ANGLE) ?
            {3'h0, deg_shift[8:0]} : adj;
         for (e = 0; e < 8; e = e + 1) begin : g_entry
            wire [11:0] lo;
            wire [11:0] hi;
            assign lo = table_to_count(mode_run[p], res_run[p], tbl[p * 8 + e][15:0]);
            assign hi = table_to_count(mode_run[p], res_run[p], tbl[p * 8 + e][31:16]);
            assign in_range[p * 8 + e] = (adj >= lo) && (adj <= hi);
            assign on_target[p * 8 + e] = (adj == lo);
         end
         assign any_match[p] = table_range[p] ? |in_range[p * 8 +: 8] :
            |on_target[p * 8 +: 8];
      end
   endgenerate

   always @* begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         `REG_P1_POS_LOW: rd_mux = {16'h0000, pos_bcd[15:0]};
         `REG_P1_POS_HIGH: rd_mux = 32'h0000_0000;
         `REG_P2_POS_LOW: rd_mux = {16'h0000, pos_bcd[31:16]};
         `REG_P2_POS_HIGH: rd_mux = 32'h0000_0000;
         `REG_P1_STATUS: rd_mux = {23'h000000, comparing[0], range_flags[7:0]};
         `REG_P2_STATUS: rd_mux = {23'h000000, comparing[1], range_flags[15:8]};
         `REG_ORIGIN_CTRL: rd_mux = {29'h00000000, origin_bits, 1'b0};
         `REG_FAULT_FLAG: rd_mux = {16'h0000, fault, 15'h0000};
         `REG_ERROR_CODE: rd_mux = {16'h0000, err_code, 8'h00};
         `REG_P1_OFFSET: rd_mux = {16'h0000, offset_reg[0]};
         `REG_P2_OFFSET: rd_mux = {16'h0000, offset_reg[1]};
         `REG_P1_CONFIG: rd_mux = {16'h0000, cfg_reg[0]};
         `REG_P2_CONFIG: rd_mux = {16'h0000, cfg_reg[1]};
         `REG_RUN_CTRL: rd_mux = {30'h00000000, irq_mask, run};
         `REG_RESULT: rd_mux = result;
         default: begin
            if (avs_address >= `REG_TABLE_BASE && avs_address <= `REG_TABLE_LAST) begin
               rd_mux = tbl[tidx[3:0]];
            end
         end
      endcase
   end

   integer i;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= 24'h000000;
         sync2 <= 24'h000000;
         sync3 <= 24'h000000;
         enc_stable <= 24'h000000;
         enc_sample <= 24'h000000;
         for (i = 0; i < 2; i = i + 1) begin
            cfg_reg[i] <= `CONFIG_RESET;
            offset_reg[i] <= `OFFSET_RESET;
            res_run[i] <= `RES_8;
            mode_run[i] <= `MODE_COUNTS;
            offset_active[i] <= 12'h000;
         end
         for (i = 0; i < 16; i = i + 1) begin
            tbl[i] <= 32'h0000_0000;
         end
         table_range <= 2'h0;
         comparing <= 2'h0;
         range_flags <= 16'h0000;
         match_prev <= 2'h0;
         pos_bcd <= 32'h0000_0000;
         origin_bits <= 2'h0;
         run <= 1'b0;
         irq_mask <= 1'b0;
         fault <= 1'b0;
         err_code <= `ERR_NONE;
         result <= 32'h0000_0000;
         tick_cnt <= 17'h00000;
         tick <= 1'b0;
         run_prev <= 1'b0;
         avs_readdata <= 32'h0000_0000;
         avs_waitrequest <= 1'b1;
         compare_irq <= 1'b0;
      end else begin
         // three-stage input, change taken once stages 2 and 3 agree
         sync1 <= enc_in;
         sync2 <= sync1;
         sync3 <= sync2;
         enc_stable <= (sync2 & sync3) | (enc_stable & (sync2 ^ sync3));

         // 4 kHz sample strobe
         if (tick_cnt == SAMPLE_CYCLES - 1) begin
            tick_cnt <= 17'h00000;
            tick <= 1'b1;
         end else begin
            tick_cnt <= tick_cnt + 17'h00001;
            tick <= 1'b0;
         end
         if (tick && run) begin
            enc_sample <= enc_stable;
         end

         // bus handshake: one wait cycle, then complete
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_readdata <= rd_mux;
         end

         run_prev <= run;
         if (run && !run_prev) begin
            for (i = 0; i < 2; i = i + 1) begin
               res_run[i] <= cfg_reg[i][7:0];
               mode_run[i] <= cfg_reg[i][15:8];
            end
            if (new_res0 > `RES_12 || cfg_reg[0][15:8] > `MODE_ANGLE ||
               new_res1 > `RES_12 || cfg_reg[1][15:8] > `MODE_ANGLE) begin
               fault <= 1'b1;
               err_code <= `ERR_SETUP;
            end else begin
               fault <= 1'b0;
               err_code <= `ERR_NONE;
            end
         end
         if (!run) begin
            if (origin_bits[1]) begin
               offset_active[0] <= origin_bin0[11:0];
            end
            if (origin_bits[2]) begin
               offset_active[1] <= origin_bin1[11:0];
            end
         end

         // publish values and compare once per sample
         compare_irq <= 1'b0;
         if (tick && run) begin
            pos_bcd <= {bin_to_bcd(pv_all[23:12]), bin_to_bcd(pv_all[11:0])};
            match_prev <= any_match & comparing;
            for (i = 0; i < 2; i = i + 1) begin
               if (comparing[i] && table_range[i]) begin
                  range_flags[i * 8 +: 8] <= in_range[i * 8 +: 8];
               end else begin
                  range_flags[i * 8 +: 8] <= 8'h00;
               end
            end
            compare_irq <= |(any_match & comparing & ~match_prev) & ~irq_mask;
         end

         if (access && avs_write) begin
            case (avs_address)
               `REG_ORIGIN_CTRL: origin_bits <= avs_writedata[`P2_ORIGIN_BIT:`P1_ORIGIN_BIT];
               `REG_P1_OFFSET: offset_reg[0] <= avs_writedata[15:0];
               `REG_P2_OFFSET: offset_reg[1] <= avs_writedata[15:0];
               `REG_P1_CONFIG: cfg_reg[0] <= avs_writedata[15:0];
               `REG_P2_CONFIG: cfg_reg[1] <= avs_writedata[15:0];
               `REG_RUN_CTRL: begin
                  run <= avs_writedata[`RUN_BIT];
                  irq_mask <= avs_writedata[`MASK_BIT];
               end
               `REG_COMMAND: begin
                  case (avs_writedata[1:0])
                     `OP_TABLE: begin
                        table_range[avs_writedata[`CMD_PORT_BIT]] <= avs_writedata[8];
                        comparing[avs_writedata[`CMD_PORT_BIT]] <= ~avs_writedata[9];
                     end
                     `OP_CONTROL: begin
                        if (avs_writedata[9:8] == `CTRL_START) begin
                           comparing[avs_writedata[`CMD_PORT_BIT]] <= 1'b1;
                        end else if (avs_writedata[9:8] == `CTRL_STOP) begin
                           comparing[avs_writedata[`CMD_PORT_BIT]] <= 1'b0;
                        end else if (avs_writedata[9:8] == `CTRL_PRESET) begin
                           offset_active[avs_writedata[`CMD_PORT_BIT]] <= preset_off[11:0];
                        end
                     end
                     `OP_READ: begin
                        if (avs_writedata[8]) begin
                           result <= avs_writedata[`CMD_PORT_BIT] ?
                              {23'h000000, comparing[1], range_flags[15:8]} :
                              {23'h000000, comparing[0], range_flags[7:0]};
                        end else begin
                           result <= avs_writedata[`CMD_PORT_BIT] ?
                              {16'h0000, pos_bcd[31:16]} : {16'h0000, pos_bcd[15:0]};
                        end
                     end
                     default: begin
                     end
                  endcase
               end
               default: begin
                  if (avs_address >= `REG_TABLE_BASE && avs_address <= `REG_TABLE_LAST) begin
                     tbl[tidx[3:0]] <= avs_writedata;
                  end
               end
            endcase
         end
      end
   end

endmodule

// *** encoder_counter_props.sv ***
// Purpose: bus and output checks for the dual encoder counter
// Assumes: sees only the top module ports
// Notes: bound after endmodule
`timescale 1ns/1ns
module encoder_counter_checker #(
   parameter SAMPLE_CYCLES = 31250
) (
   input wire clk, // clock
   input wire reset_n, // async reset
   input wire [5:0] avs_address, // word address
   input wire avs_read, // read request
   input wire avs_write, // write request
   input wire [31:0] avs_writedata, // write data
   input wire [31:0] avs_readdata, // read data
   input wire avs_waitrequest, // stall
   input wire [11:0] enc1_gray, // port 1 word
   input wire [11:0] enc2_gray, // port 2 word
   input wire compare_irq // comparison pulse
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire taken = (avs_read | avs_write) & avs_waitrequest;
   wire rd_taken = avs_read & avs_waitrequest;
   wire idle = !avs_read & !avs_write & avs_waitrequest;

   a_wait_answer: assert property (taken |=> !avs_waitrequest)
      else $error("request not answered");
   a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_idle_stall: assert property (idle |=> avs_waitrequest && $stable(avs_readdata))
      else $error("answer or data change without request");
   a_unmapped_zero: assert property (rd_taken && avs_address[5] |=> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_high_zero: assert property (rd_taken && (avs_address == 6'h01 || avs_address == 6'h03)
      |=> avs_readdata == 32'h0) else $error("high position word not zero");
   a_pos_bcd: assert property (rd_taken && (avs_address == 6'h00 || avs_address == 6'h02)
      |=> avs_readdata[31:16] == 16'h0 && avs_readdata[15:12] <= 4'h4
      && avs_readdata[11:8] <= 4'h9 && avs_readdata[7:4] <= 4'h9 && avs_readdata[3:0] <= 4'h9)
      else $error("position word not bcd");
   a_status_width: assert property (rd_taken
      && (avs_address == 6'h04 || avs_address == 6'h05)
      |=> avs_readdata[31:9] == 23'h0) else $error("status spare bits set");
   a_error_code: assert property (rd_taken && avs_address == 6'h08
      |=> avs_readdata == 32'h0 || avs_readdata == 32'h300) else $error("bad error code");
   a_irq_pulse: assert property (compare_irq |=> !compare_irq)
      else $error("interrupt longer than one cycle");

   c_irq: cover property (compare_irq);
   c_unmapped: cover property (rd_taken && avs_address[5]);
   c_write: cover property (avs_write && !avs_waitrequest);
endmodule

bind dual_absolute_encoder_counter encoder_counter_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
   .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .enc1_gray(enc1_gray), .enc2_gray(enc2_gray),
   .compare_irq(compare_irq));

// *** abs_encoder_model.sv ***
// Purpose: absolute rotary encoder with parallel gray output
// Assumes: position stays within the chosen resolution
// Notes: unused upper lines toggle every cycle
`timescale 1ns/1ns
module abs_encoder_model (
   input wire clk, // clock
   input wire [11:0] position, // shaft position
   input wire [1:0] res_sel, // 0 8 bit, 1 10 bit, 2 12 bit
   output reg [11:0] gray // gray word
);
   wire [11:0] mask;
   reg [11:0] junk = 12'hA5C;
   assign mask = (res_sel == 2'h0) ? 12'h0FF : (res_sel == 2'h1) ? 12'h3FF : 12'hFFF;
   always @(posedge clk) begin
      junk <= ~junk;
      gray <= ((position ^ (position >> 1)) & mask) | (junk & ~mask);
   end
endmodule

// *** dual_absolute_encoder_counter_tb_top.sv ***
// Purpose: self-checking bench for the dual encoder counter
// Assumes: two-cycle Avalon access, sample tick every 8 cycles
// Notes: encoder models drive both ports
`timescale 1ns/1ns
module dual_absolute_encoder_counter_tb_top;
   reg clk;
   reg reset_n;
   reg [5:0] avs_address;
   reg avs_read;
   reg avs_write;
   reg [31:0] avs_writedata;
   wire [31:0] avs_readdata;
   wire avs_waitrequest;
   wire [11:0] enc1_gray;
   wire [11:0] enc2_gray;
   wire compare_irq;
   reg [11:0] pos1;
   reg [11:0] pos2;
   reg [1:0] res1;
   reg [1:0] res2;
   integer error_cnt = 0;
   integer total_checks = 0;
   integer irq_cnt = 0;
   integer snap;
   integer cyc = 0;

   dual_absolute_encoder_counter #(.SAMPLE_CYCLES(8)) u_dut (
      .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .enc1_gray(enc1_gray), .enc2_gray(enc2_gray),
      .compare_irq(compare_irq));
   abs_encoder_model u_enc1 (.clk(clk), .position(pos1), .res_sel(res1), .gray(enc1_gray));
   abs_encoder_model u_enc2 (.clk(clk), .position(pos2), .res_sel(res2), .gray(enc2_gray));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      if (compare_irq === 1'b1) irq_cnt <= irq_cnt + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         give_verdict;
      end
   end

   task give_verdict;
      begin
         $display("checks %0d errors %0d", total_checks, error_cnt);
         if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask

   task check(input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
         end
      end
   endtask

   // hold request until waitrequest is sampled low
   task bus(input rd, input [5:0] a, input [31:0] d, output [31:0] q);
      integer n;
      begin
         n = 0;
         @(posedge clk);
         avs_address <= a;
         avs_writedata <= d;
         avs_read <= rd;
         avs_write <= !rd;
         @(posedge clk);
         while (avs_waitrequest !== 1'b0 && n < 100) begin
            n = n + 1;
            @(posedge clk);
         end
         if (n >= 100) check(32'h1, 32'h0);
         q = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask

   task wr(input [5:0] a, input [31:0] d);
      reg [31:0] q;
      begin
         bus(1'b0, a, d, q);
      end
   endtask

   task rd_chk(input [5:0] a, input [31:0] exp);
      reg [31:0] q;
      begin
         bus(1'b1, a, 32'h0, q);
         check(q, exp);
      end
   endtask

   // three sync stages plus up to two ticks
   task settle;
      begin
         repeat (40) @(posedge clk);
      end
   endtask

   function [31:0] bcd(input integer v);
      begin
         bcd = 32'h0;
         bcd[15:12] = v / 1000 % 10;
         bcd[11:8] = v / 100 % 10;
         bcd[7:4] = v / 10 % 10;
         bcd[3:0] = v % 10;
      end
   endfunction

   initial begin
      reset_n = 1'b0;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      pos1 = 12'd10;
      pos2 = 12'd1023;
      res1 = 2'h0;
      res2 = 2'h1;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd_chk(6'h0B, 32'h0);
      rd_chk(6'h0C, 32'h0);
      rd_chk(6'h04, 32'h0);
      rd_chk(6'h08, 32'h0);
      rd_chk(6'h20, 32'h0);
      wr(6'h09, 32'h0000_4095);
      rd_chk(6'h09, 32'h0000_4095);
      wr(6'h09, 32'h0);
      wr(6'h0C, 32'h0000_0001);
      wr(6'h0D, 32'h1);
      settle;
      rd_chk(6'h00, bcd(10));
      rd_chk(6'h02, bcd(1023));
      rd_chk(6'h03, 32'h0);
      wr(6'h00, 32'h0000_FFFF);
      rd_chk(6'h00, bcd(10));
      // angle mode, config taken at run start
      wr(6'h0D, 32'h0);
      wr(6'h0B, 32'h0000_0102);
      wr(6'h0C, 32'h0000_0100);
      res1 <= 2'h2;
      res2 <= 2'h0;
      pos1 <= 12'd2048;
      pos2 <= 12'd64;
      wr(6'h0D, 32'h1);
      settle;
      rd_chk(6'h00, bcd(180));
      rd_chk(6'h02, bcd(90));
      // angle range table on port 1, 12 bit, shaft at 180 degrees
      wr(6'h10, 32'h0300_0200);
      wr(6'h11, 32'h0180_0175);
      wr(6'h0E, 32'h0000_0100);
      settle;
      rd_chk(6'h04, 32'h0000_0102);
      // target table on port 1, counts 8 bit
      wr(6'h0D, 32'h0);
      wr(6'h0B, 32'h0);
      wr(6'h0C, 32'h0);
      res1 <= 2'h0;
      pos1 <= 12'd10;
      pos2 <= 12'd200;
      wr(6'h0D, 32'h1);
      wr(6'h10, 32'h0000_0100);
      wr(6'h0E, 32'h0000_0000);
      settle;
      rd_chk(6'h04, 32'h0000_0100);
      rd_chk(6'h05, 32'h0);
      snap = irq_cnt;
      pos1 <= 12'd100;
      settle;
      check(irq_cnt - snap, 1);
      wr(6'h0E, 32'h0000_0101);
      rd_chk(6'h04, 32'h0);
      // range table
      wr(6'h10, 32'h0150_0050);
      wr(6'h11, 32'h0300_0200);
      wr(6'h0E, 32'h0000_0300);
      rd_chk(6'h04, 32'h0);
      wr(6'h0E, 32'h0000_0001);
      settle;
      rd_chk(6'h04, 32'h0000_0101);
      pos1 <= 12'd250;
      settle;
      rd_chk(6'h04, 32'h0000_0102);
      snap = irq_cnt;
      wr(6'h0D, 32'h3);
      pos1 <= 12'd10;
      settle;
      pos1 <= 12'd100;
      settle;
      check(irq_cnt - snap, 0);
      wr(6'h0D, 32'h1);
      pos1 <= 12'd10;
      settle;
      pos1 <= 12'd100;
      settle;
      check(irq_cnt - snap, 1);
      wr(6'h0E, 32'h0000_0002);
      rd_chk(6'h0F, bcd(100));
      wr(6'h0E, 32'h0000_0102);
      rd_chk(6'h0F, 32'h0000_0101);
      wr(6'h0E, 32'h0000_0012);
      rd_chk(6'h0F, bcd(200));
      // origin offset in program mode, then position preset
      wr(6'h0D, 32'h0);
      wr(6'h09, 32'h0000_0005);
      wr(6'h06, 32'h0000_0002);
      wr(6'h0D, 32'h1);
      settle;
      rd_chk(6'h00, bcd(95));
      wr(6'h0E, 32'h0050_0201);
      settle;
      rd_chk(6'h00, bcd(50));
      // bad resolution code gives setup fault
      wr(6'h0D, 32'h0);
      wr(6'h0B, 32'h0000_0003);
      wr(6'h0D, 32'h1);
      settle;
      rd_chk(6'h07, 32'h0000_8000);
      rd_chk(6'h08, 32'h0000_0300);
      give_verdict;
   end
endmodule
